// ==== bench/cap_pin_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module cap_pin_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // levels asked for by the bench, and the pins as driven
  input  wire logic [5:0] want,
  output logic      [5:0] pins
);
  // pins move just after a rising edge and hold for a whole cycle
  // or more, so each change is one clean edge for the synchroniser
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pins <= 6'h00;
    end else begin
      pins <= want;
    end
  end
endmodule // cap_pin_model

`default_nettype wire

// ==== bench/counter_array_capture_compare_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CMP(g, e) check_eq(16'(g), 16'(e))

module counter_array_capture_compare_bench;
  typedef struct {
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] ra;
    logic [7:0] e;
  } row_s;

  logic       clk                 = 1'b0;
  logic       rst_b               = 1'b0;
  logic [7:0] sfr_addr            = 8'h00;
  logic [7:0] sfr_wdata           = 8'h00;
  logic       sfr_wr              = 1'b0;
  logic       sfr_rd              = 1'b0;
  logic       watchdog_enable_bit = 1'b0;
  logic [5:0] want                = 6'h00;
  logic [5:0] pins;
  logic [5:0] module_out;
  logic [7:0] sfr_rdata;
  logic       array_irq;
  logic [15:0] c;
  int         miscompares         = 0;
  int         comparisons         = 0;
  // write, then read: plain registers, register select, an unmapped address and the high-byte snapshot
  row_s rows [9] = '{
    '{8'he5, 8'hb7, 8'he5, 8'hb7},
    '{8'hed, 8'h5a, 8'hed, 8'h5a},
    '{8'hf5, 8'ha5, 8'hf5, 8'ha5},
    '{8'hd9, 8'h83, 8'hd9, 8'h83},
    '{8'hed, 8'h3c, 8'hed, 8'h3c},
    '{8'hd9, 8'h03, 8'hed, 8'h5a},
    '{8'h80, 8'hff, 8'h80, 8'h00},
    '{8'hf9, 8'h12, 8'hf9, 8'h12},
    '{8'hfa, 8'h34, 8'hfa, 8'h00}
  };
  logic [7:0] codes [4] = '{8'h21, 8'h11, 8'h31, 8'h20};

  // free-running system clock
  always #5 clk = ~clk;

  counter_array_capture_compare #(.NUM_MOD(6)) dut_u (
    .clk                 (clk),
    .rst_b               (rst_b),
    .sfr_addr            (sfr_addr),
    .sfr_wdata           (sfr_wdata),
    .sfr_wr              (sfr_wr),
    .sfr_rd              (sfr_rd),
    .sfr_rdata           (sfr_rdata),
    .watchdog_enable_bit (watchdog_enable_bit),
    .module_capture_pin  (pins),
    .module_out          (module_out),
    .array_irq           (array_irq)
  );

  cap_pin_model pin_u (
    .clk   (clk),
    .rst_b (rst_b),
    .want  (want),
    .pins  (pins)
  );

  task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobes rise and fall on falling edges, one request every two cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    `CMP(sfr_rdata, e);
  endtask

  task automatic set_cnt(input logic [15:0] val);
    wr(8'hf9, val[7:0]);
    wr(8'hfa, val[15:8]);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic count_high(input int m, input int n);
    c = 16'h0000;
    repeat (n) begin
      @(negedge clk);
      if (module_out[m] === 1'b1) c = c + 16'h0001;
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  initial begin
    idle(4);
    rst_b = 1'b1;
    idle(4);
    `CMP(module_out, 6'h00);
    `CMP(array_irq, 1'b0);
    rd_chk(8'hf9, 8'h00);
    rd_chk(8'hfa, 8'h00);
    rd_chk(8'hd8, 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(rows[i].wa, rows[i].wd);
      rd_chk(rows[i].ra, rows[i].e);
    end
    // counter bytes are locked while the watchdog runs
    watchdog_enable_bit = 1'b1;
    set_cnt(16'hffff);
    rd_chk(8'hf9, 8'h12);
    rd_chk(8'hfa, 8'h34);
    watchdog_enable_bit = 1'b0;
    // high byte must come from the stopped-time snapshot, not live
    set_cnt(16'h12ff);
    rd_chk(8'hf9, 8'hff);
    wr(8'hd8, 8'h40);
    idle(4);
    rd_chk(8'hfa, 8'h12);
    wr(8'hd8, 8'h00);
    // rising, falling, both, rising without interrupt enable
    for (int m = 0; m < 4; m++) begin
      set_cnt(16'h0150 + 16'(m));
      wr(8'he0 + 8'(m), codes[m]);
      want[m] = 1'b1;
      idle(6);
      `CMP(array_irq, codes[m][5] & codes[m][0]);
      if (codes[m][5] & codes[m][4]) rd_chk(8'hda, 8'h01 << m);
      set_cnt(16'h0260 + 16'(m));
      want[m] = 1'b0;
      idle(20);
      rd_chk(8'he8 + 8'(m), codes[m][4] ? 8'h60 + 8'(m) :
             (codes[m][5] ? 8'h50 + 8'(m) : 8'h00));
      rd_chk(8'hf0 + 8'(m), codes[m][4] ? 8'h02 :
             (codes[m][5] ? 8'h01 : 8'h00));
      rd_chk(8'hd8, 8'h01 << m);
      wr(8'hd8, 8'h00);
      rd_chk(8'hd8, 8'h00);
    end
    // 10-bit pwm: reload and compare loaded alike for two modules
    for (int p = 0; p < 2; p++) begin
      wr(8'hd9, p == 0 ? 8'h82 : 8'h22);
      wr(8'he8, 8'h00);
      wr(8'hf0, 8'h01);
      wr(8'he9, 8'h00);
      wr(8'hf1, 8'h02);
    end
    wr(8'he0, 8'h42);
    wr(8'he1, 8'h42);
    wr(8'he2, 8'h02);
    wr(8'he3, 8'h00);
    set_cnt(16'h0000);
    wr(8'hd8, 8'h40);
    idle(20);
    count_high(0, 1024);
    `CMP(c, 16'h0100);
    count_high(1, 1024);
    `CMP(c, 16'h0200);
    count_high(2, 1024);
    `CMP(c, 16'h0000);
    rd_chk(8'hd9, 8'h62);
    `CMP(array_irq, 1'b1);
    // 8-bit: module 1 follows the shared length, low reloads from high
    wr(8'hd9, 8'h00);
    wr(8'he8, 8'h40);
    wr(8'hf0, 8'h40);
    idle(300);
    count_high(0, 512);
    `CMP(c, 16'h0080);
    count_high(1, 512);
    `CMP(c, 16'h0004);
    // 16-bit pwm compares the whole word despite the 8-bit length
    wr(8'hd8, 8'h00);
    wr(8'he1, 8'hc2);
    set_cnt(16'h0100);
    wr(8'hd8, 8'h40);
    idle(4);
    count_high(1, 64);
    `CMP(c, 16'h0040);
    // match flags: module 4 enabled, module 5 not
    wr(8'hd8, 8'h00);
    for (int m = 0; m < 4; m++) wr(8'he0 + 8'(m), 8'h00);
    wr(8'he4, 8'h48);
    wr(8'he5, 8'h40);
    for (int m = 4; m < 6; m++) begin
      wr(8'he8 + 8'(m), 8'h10);
      wr(8'hf0 + 8'(m), 8'h00);
    end
    set_cnt(16'h0000);
    wr(8'hd8, 8'h40);
    idle(40);
    rd_chk(8'hd8, 8'h50);
    `CMP(array_irq, 1'b0);
    wr(8'he4, 8'h49);
    idle(2);
    `CMP(array_irq, 1'b1);
    // second reset in mid-run brings everything back to zero
    rst_b = 1'b0;
    idle(4);
    rst_b = 1'b1;
    idle(4);
    `CMP(array_irq, 1'b0);
    rd_chk(8'hd8, 8'h00);
    rd_chk(8'he4, 8'h00);
    conclude();
  end
endmodule // counter_array_capture_compare_bench

`default_nettype wire

// ==== design/capture_edge_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cca_cfg.svh"

module capture_edge_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // raw capture pin
  input  wire logic pin,
  // synchronised level and edge pulses
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic                        meta_q;
  logic                        sync_q;
  logic                        last_q;
  logic [`CCA_SYNC_DEPTH-1:0]  valid_q;

  // two-flop synchroniser plus history flop; valid_q masks the
  // start-up so a pin held high at reset gives no false edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      last_q  <= 1'b0;
      valid_q <= '0;
    end else begin
      meta_q  <= pin;
      sync_q  <= meta_q;
      last_q  <= sync_q;
      valid_q <= {valid_q[`CCA_SYNC_DEPTH-2:0], 1'b1};
    end
  end

  // edges only on the synchronised copy  [R16]
  assign level = sync_q;
  assign rise  = valid_q[`CCA_SYNC_DEPTH-1] & sync_q & ~last_q;
  assign fall  = valid_q[`CCA_SYNC_DEPTH-1] & ~sync_q & last_q;

  // one transition never yields two consecutive edge pulses
  a_one_edge: assert property (@(posedge clk) disable iff (!rst_b) // [R16]
    (rise || fall) |=> !(rise || fall))
    else $error("edge pulse lasted more than one cycle");

endmodule // capture_edge_sync

`default_nettype wire

// ==== design/cca_cfg.svh ====
`ifndef CCA_CFG_SVH
`define CCA_CFG_SVH

// byte addresses on the special function register port
`define CCA_CNT_LO_ADDR  8'hf9
`define CCA_CNT_HI_ADDR  8'hfa
`define CCA_CTRL_ADDR    8'hd8
`define CCA_PCFG_ADDR    8'hd9
`define CCA_PINLVL_ADDR  8'hda
`define CCA_MODE_BASE    8'he0
`define CCA_CMPL_BASE    8'he8
`define CCA_CMPH_BASE    8'hf0

// array control register bits
`define CCA_CTRL_RUN     6
`define CCA_CTRL_OVF     7

// pwm configuration register bits
`define CCA_PCFG_ARSEL   7
`define CCA_PCFG_FOVF    6
`define CCA_PCFG_FOVIE   5
`define CCA_PCFG_CLS_HI  1
`define CCA_PCFG_CLS_LO  0

// module mode register bits
`define CCA_MD_PWM16     7
`define CCA_MD_ECOM      6
`define CCA_MD_RISE      5
`define CCA_MD_FALL      4
`define CCA_MD_MAT       3
`define CCA_MD_TOG       2
`define CCA_MD_PWM       1
`define CCA_MD_IE        0

// reset values and field constants
`define CCA_RST_BYTE     8'h00
`define CCA_RST_WORD     16'h0000
`define CCA_CNT_STEP     16'h0001
`define CCA_CNT_TOP      16'hffff
`define CCA_FLD_MASK8    16'h00ff
`define CCA_SYNC_DEPTH   3

`endif

// ==== design/cca_pkg.sv ====
package cca_pkg;

  // operating mode of one capture/compare module
  typedef enum logic [2:0] {
    MODE_CAPTURE,
    MODE_TIMER,
    MODE_HSO,
    MODE_FREQ,
    MODE_PWMN,
    MODE_PWM16
  } chan_mode_e;

endpackage

// ==== design/compare_channel.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cca_cfg.svh"

module compare_channel
  import cca_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // configuration
  input  wire logic [7:0]  mode,
  input  wire logic [15:0] fld_mask,
  // counter and compare value
  input  wire logic [15:0] count,
  input  wire logic [15:0] cmp,
  // results
  output logic             match,
  output logic             pin_out_q
);

  chan_mode_e kind;
  logic       hit;
  logic       hit_q;

  // mode decode from the mode register bits
  always_comb begin
    kind = MODE_CAPTURE;
    if (mode[`CCA_MD_PWM] && mode[`CCA_MD_TOG]) begin
      kind = MODE_FREQ;
    end else if (mode[`CCA_MD_PWM] && mode[`CCA_MD_PWM16]) begin
      kind = MODE_PWM16; // field length ignored  [R13]
    end else if (mode[`CCA_MD_PWM]) begin
      kind = MODE_PWMN;
    end else if (mode[`CCA_MD_MAT] && mode[`CCA_MD_TOG]) begin
      kind = MODE_HSO;
    end else if (mode[`CCA_MD_MAT]) begin
      kind = MODE_TIMER;
    end
  end

  // comparator; switched off by the comparator enable  [R6]
  always_comb begin
    case (kind)
      MODE_FREQ: hit = (count[7:0] == cmp[7:0]);
      MODE_PWMN: hit = ((count & fld_mask) == (cmp & fld_mask));
      default:   hit = (count == cmp);
    endcase
    hit = hit & mode[`CCA_MD_ECOM];
  end

  // match is the first cycle of equality, so a stopped counter
  // does not keep firing events
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit;
    end
  end

  assign match = hit & ~hit_q;

  // output pin per mode; pwm is forced low with comparator off  [R6]
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_out_q <= 1'b0;
    end else begin
      case (kind)
        MODE_HSO, MODE_FREQ: if (match) pin_out_q <= ~pin_out_q;
        MODE_PWMN: pin_out_q <= mode[`CCA_MD_ECOM] &&
                     ((count & fld_mask) < (cmp & fld_mask));
        MODE_PWM16: pin_out_q <= mode[`CCA_MD_ECOM] && (count < cmp);
        default: pin_out_q <= pin_out_q;
      endcase
    end
  end

  a_pwm_off_low: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
    ((kind == MODE_PWMN || kind == MODE_PWM16) && !mode[`CCA_MD_ECOM])
      |=> !pin_out_q)
    else $error("pwm output high with comparator off");

  a_toggle_hold: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
    ((kind == MODE_HSO || kind == MODE_FREQ) && !mode[`CCA_MD_ECOM])
      |=> $stable(pin_out_q))
    else $error("output toggled with comparator off");

  a_pwm16_duty: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
    (kind == MODE_PWM16 && mode[`CCA_MD_ECOM] && count < cmp)
      |=> pin_out_q)
    else $error("16-bit pwm output low below compare value");

endmodule // compare_channel

`default_nettype wire

// ==== design/counter_array_capture_compare.sv ====
// Overview of operation
// R1 - a valid capture pin edge copies the counter into the compare register
// R2 - rising and falling enables choose which pin edges capture
// R3 - a capture sets the module event flag and may request an interrupt
// R4 - flags are never cleared by hardware; software clears them
// R5 - with both edge enables set, software can read the pin level
// R6 - comparator off: no toggling, and pwm output held at zero
// R7 - with match enable set, a counter match sets the event flag
// R8 - per-module interrupt enable gates the flag onto the array interrupt
// R9 - field overflow of bit 8 to 11 may interrupt, per cycle length
// R10 - register select maps compare addresses to compare or reload register
// R11 - all 8 to 11-bit pwm modules share one cycle length
// R12 - cycle length codes 00 to 11 give 8 to 11-bit pwm
// R13 - 16-bit pwm enable overrides the cycle length setting
// R14 - counter high byte reads a snapshot taken when low byte is read
// R15 - counter byte writes are ignored while the watchdog is enabled
// R16 - capture pins are synchronised and edge-detected once per transition
`timescale 1ns/100ps
`default_nettype none
`include "cca_cfg.svh"

module counter_array_capture_compare
  import cca_pkg::*;
#(
  parameter int NUM_MOD = 6
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // special function register port
  input  wire logic [7:0]         sfr_addr,
  input  wire logic [7:0]         sfr_wdata,
  input  wire logic               sfr_wr,
  input  wire logic               sfr_rd,
  output logic      [7:0]         sfr_rdata,
  // watchdog state from the rest of the chip
  input  wire logic               watchdog_enable_bit,
  // module pins
  input  wire logic [NUM_MOD-1:0] module_capture_pin,
  output logic      [NUM_MOD-1:0] module_out,
  // interrupt request
  output logic                    array_irq
);

  logic [15:0]        count_q;
  logic [7:0]         snap_q;
  logic               run_q;
  logic               ovf_q;
  logic               arsel_q;
  logic               fovf_q;
  logic               fovie_q;
  logic [1:0]         cls_q;
  logic [NUM_MOD-1:0] flag_q;
  logic [NUM_MOD-1:0] pin_level;
  logic [NUM_MOD-1:0] capture;
  logic [NUM_MOD-1:0] ie_vec;
  logic [7:0]         mode_v [NUM_MOD];
  logic [15:0]        cmp_v  [NUM_MOD];
  logic [15:0]        rld_v  [NUM_MOD];
  logic [15:0]        fld_mask;
  logic [7:0]         rd_mux;
  logic               wr_lo;
  logic               wr_hi;
  logic               wr_ctrl;
  logic               wr_pcfg;
  logic               cnt_tick;
  logic               cnt_wrap;
  logic               fld_ovf;

  // counter writes are dropped while the watchdog owns the counter  [R15]
  assign wr_lo   = sfr_wr && (sfr_addr == `CCA_CNT_LO_ADDR)
                   && !watchdog_enable_bit;
  assign wr_hi   = sfr_wr && (sfr_addr == `CCA_CNT_HI_ADDR)
                   && !watchdog_enable_bit;
  assign wr_ctrl = sfr_wr && (sfr_addr == `CCA_CTRL_ADDR);
  assign wr_pcfg = sfr_wr && (sfr_addr == `CCA_PCFG_ADDR);

  // one shared field mask for every n-bit pwm module  [R11]
  // code 0..3 widens the field from 8 to 11 bits  [R12]
  assign fld_mask = (`CCA_FLD_MASK8 << cls_q) | `CCA_FLD_MASK8;

  assign cnt_tick = run_q && !wr_lo && !wr_hi;
  assign cnt_wrap = cnt_tick && (count_q == `CCA_CNT_TOP);
  assign fld_ovf  = cnt_tick && ((count_q & fld_mask) == fld_mask);

  // counter: a software write beats the increment
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_q <= `CCA_RST_WORD;
    end else if (wr_lo) begin
      count_q[7:0] <= sfr_wdata; // [R15]
    end else if (wr_hi) begin
      count_q[15:8] <= sfr_wdata; // [R15]
    end else if (run_q) begin
      count_q <= count_q + `CCA_CNT_STEP;
    end
  end

  // array control: run bit and counter overflow flag, set wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      run_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        run_q <= sfr_wdata[`CCA_CTRL_RUN];
      end
      ovf_q <= (wr_ctrl ? sfr_wdata[`CCA_CTRL_OVF] : ovf_q) | cnt_wrap;
    end
  end

  // pwm configuration: reload select, field overflow flag and enable
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arsel_q <= 1'b0;
      fovie_q <= 1'b0;
      cls_q   <= 2'h0;
      fovf_q  <= 1'b0;
    end else begin
      if (wr_pcfg) begin
        arsel_q <= sfr_wdata[`CCA_PCFG_ARSEL];
        fovie_q <= sfr_wdata[`CCA_PCFG_FOVIE];
        cls_q   <= sfr_wdata[`CCA_PCFG_CLS_HI:`CCA_PCFG_CLS_LO];
      end
      fovf_q <= (wr_pcfg ? sfr_wdata[`CCA_PCFG_FOVF] : fovf_q) | fld_ovf;
    end
  end

  // per-module logic
  for (genvar n = 0; n < NUM_MOD; n++) begin : g_mod
    logic [7:0]  mode_q;
    logic [15:0] cmp_q;
    logic [15:0] rld_q;
    logic        rise;
    logic        fall;
    logic        match;
    logic        wr_mode;
    logic        wr_cl;
    logic        wr_ch;
    logic        is_freq;
    logic        is_pwmn;

    assign wr_mode = sfr_wr && (sfr_addr == `CCA_MODE_BASE + 8'(n));
    assign wr_cl   = sfr_wr && (sfr_addr == `CCA_CMPL_BASE + 8'(n));
    assign wr_ch   = sfr_wr && (sfr_addr == `CCA_CMPH_BASE + 8'(n));
    assign is_freq = mode_q[`CCA_MD_PWM] && mode_q[`CCA_MD_TOG];
    assign is_pwmn = mode_q[`CCA_MD_PWM] && !mode_q[`CCA_MD_TOG]
                     && !mode_q[`CCA_MD_PWM16];

    capture_edge_sync u_edge (
      .clk   (clk),
      .rst_b (rst_b),
      .pin   (module_capture_pin[n]),
      .level (pin_level[n]),
      .rise  (rise),
      .fall  (fall)
    );

    // edge type chosen by the two capture enables  [R2]
    assign capture[n] = (rise && mode_q[`CCA_MD_RISE])
                        || (fall && mode_q[`CCA_MD_FALL]);

    compare_channel u_chan (
      .clk       (clk),
      .rst_b     (rst_b),
      .mode      (mode_q),
      .fld_mask  (fld_mask),
      .count     (count_q),
      .cmp       (cmp_q),
      .match     (match),
      .pin_out_q (module_out[n])
    );

    // mode register
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        mode_q <= `CCA_RST_BYTE;
      end else if (wr_mode) begin
        mode_q <= sfr_wdata;
      end
    end

    // capture/compare register; capture has priority over software
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        cmp_q <= `CCA_RST_WORD;
      end else if (capture[n]) begin
        cmp_q <= count_q; // [R1]
      end else if (wr_cl && !arsel_q) begin
        cmp_q[7:0] <= sfr_wdata; // [R10]
      end else if (wr_ch && !arsel_q) begin
        cmp_q[15:8] <= sfr_wdata; // [R10]
      end else if (fld_ovf && is_pwmn) begin
        // new duty takes effect only at a cycle boundary, no glitch
        if (cls_q == 2'h0) begin
          cmp_q[7:0] <= cmp_q[15:8];
        end else begin
          cmp_q <= rld_q;
        end
      end else if (match && is_freq) begin
        cmp_q[7:0] <= cmp_q[7:0] + cmp_q[15:8];
      end
    end

    // auto-reload register, reached when register select is set
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        rld_q <= `CCA_RST_WORD;
      end else if (wr_cl && arsel_q) begin
        rld_q[7:0] <= sfr_wdata; // [R10]
      end else if (wr_ch && arsel_q) begin
        rld_q[15:8] <= sfr_wdata; // [R10]
      end
    end

    // event flag: hardware sets win, only software clears  [R4]
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        flag_q[n] <= 1'b0;
      end else begin
        flag_q[n] <= (wr_ctrl ? sfr_wdata[n] : flag_q[n])
                     | capture[n] // [R3]
                     | (match && mode_q[`CCA_MD_MAT]); // [R7]
      end
    end

    assign mode_v[n] = mode_q;
    assign cmp_v[n]  = cmp_q;
    assign rld_v[n]  = rld_q;
    assign ie_vec[n] = mode_q[`CCA_MD_IE];

    a_capture_load: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
      capture[n] |=> (cmp_q == $past(count_q)))
      else $error("capture did not load the counter value");

    a_edge_select: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
      (rise && !mode_q[`CCA_MD_RISE] && !wr_cl && !wr_ch && !fld_ovf
       && !match) |=> $stable(cmp_q))
      else $error("rising edge captured while rising enable off");

    a_capture_flag: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
      capture[n] |=> flag_q[n])
      else $error("capture did not set the event flag");

    a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
      (flag_q[n] && !wr_ctrl) |=> flag_q[n])
      else $error("event flag cleared without a software write");

    a_match_flag: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
      (match && mode_q[`CCA_MD_MAT]) |=> flag_q[n])
      else $error("enabled match did not set the event flag");
  end

  // interrupt: enabled module flags plus enabled field overflow
  assign array_irq = (|(flag_q & ie_vec)) // [R8]
                     | (fovf_q && fovie_q); // [R9]

  // read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux = `CCA_RST_BYTE;
    case (sfr_addr)
      `CCA_CNT_LO_ADDR: rd_mux = count_q[7:0];
      `CCA_CNT_HI_ADDR: rd_mux = snap_q; // [R14]
      `CCA_CTRL_ADDR: begin
        rd_mux[`CCA_CTRL_OVF]  = ovf_q;
        rd_mux[`CCA_CTRL_RUN]  = run_q;
        rd_mux[NUM_MOD-1:0]    = flag_q;
      end
      `CCA_PCFG_ADDR: begin
        rd_mux[`CCA_PCFG_ARSEL] = arsel_q;
        rd_mux[`CCA_PCFG_FOVF]  = fovf_q;
        rd_mux[`CCA_PCFG_FOVIE] = fovie_q;
        rd_mux[`CCA_PCFG_CLS_HI:`CCA_PCFG_CLS_LO] = cls_q;
      end
      `CCA_PINLVL_ADDR: rd_mux[NUM_MOD-1:0] = pin_level; // [R5]
      default: begin
        for (int i = 0; i < NUM_MOD; i++) begin
          if (sfr_addr == `CCA_MODE_BASE + 8'(i)) begin
            rd_mux = mode_v[i];
          end
          if (sfr_addr == `CCA_CMPL_BASE + 8'(i)) begin
            rd_mux = arsel_q ? rld_v[i][7:0] : cmp_v[i][7:0]; // [R10]
          end
          if (sfr_addr == `CCA_CMPH_BASE + 8'(i)) begin
            rd_mux = arsel_q ? rld_v[i][15:8] : cmp_v[i][15:8]; // [R10]
          end
        end
      end
    endcase
  end

  // registered read data, one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sfr_rdata <= `CCA_RST_BYTE;
    end else if (sfr_rd) begin
      sfr_rdata <= rd_mux;
    end
  end

  // snapshot keeps a 16-bit read coherent across two byte reads
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      snap_q <= `CCA_RST_BYTE;
    end else if (sfr_rd && (sfr_addr == `CCA_CNT_LO_ADDR)) begin
      snap_q <= count_q[15:8]; // [R14]
    end
  end

  a_snap_hold: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
    !(sfr_rd && sfr_addr == `CCA_CNT_LO_ADDR) |=> $stable(snap_q))
    else $error("snapshot changed without a low byte read");

  a_wd_block: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
    (watchdog_enable_bit && sfr_wr && sfr_addr == `CCA_CNT_HI_ADDR)
      |=> (count_q[15:8] == $past(count_q[15:8]))
          || ($past(run_q) && ($past(count_q[7:0]) == 8'hff)))
    else $error("counter high byte written while watchdog enabled");

  a_pin_read: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
    (sfr_rd && sfr_addr == `CCA_PINLVL_ADDR)
      |=> (sfr_rdata[NUM_MOD-1:0] == $past(pin_level)))
    else $error("pin level read back wrong");

  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
    ((ie_vec == '0) && !fovie_q) |-> !array_irq)
    else $error("interrupt raised with every enable off");

  a_fld_ovf_flag: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
    fld_ovf |=> fovf_q)
    else $error("field overflow did not set its flag");

endmodule // counter_array_capture_compare

`default_nettype wire
